// ===== logic/ipirq_port.sv
// four-bit input port: sync, debounce, edge flags, pulls, wake and taps
// Notes on behaviour
// - software reads pin levels any time, frozen in sleep unless wake set
// - sleep drops pulls and inputs unless wake set
// - per bit, debounced or direct input for interrupts
// - debouncer passes level stable over two ticks
// - per bit rising or falling edge requests
// - all four bits request, each own enable
// - reset clears every interrupt enable bit
// - disabled bit discards edges, latches nothing
// - enabling bit latches only the next edge
// - edge select change at level may request
// - pull only with fab option and inhibit clear
// - bits 0..2 always debounced to branch conditions
// - bits 0 and 3 clock the event counter
// - bit 3 drives millisecond counter start/stop
// - select bit picks 128 Hz or faster tap
// - edge select 0 rising, 1 falling
// - bypass 0 debounced, 1 direct
// - write one clears flag, zero leaves it
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module ipirq_port
	import ipirq_pkg::*;
#(
	parameter int unsigned DIV_SLOW_P = DIV_SLOW, // cycles per slow tap
	parameter int unsigned DIV_FAST_P = DIV_FAST // cycles per fast tap
) (
	input wire logic ref_clk_i, // reference clock, 100 MHz
	input wire logic sys_rst_i, // synchronous reset, high
	input wire logic [ADDR_W-1:0] reg_addr_i, // register offset
	input wire logic [PORT_W-1:0] reg_wdata_i, // write data
	input wire logic reg_wr_i, // write strobe
	input wire logic reg_rd_i, // read strobe
	output logic [PORT_W-1:0] reg_rdata_o, // read data, cycle after strobe
	input wire logic [PORT_W-1:0] input_pins_i, // asynchronous pins
	input wire logic [PORT_W-1:0] fab_pull_up_option_i, // pull-up fitted
	input wire logic [PORT_W-1:0] fab_pull_down_option_i, // pull-down fitted
	input wire logic sleep_i, // device in sleep
	output logic [PORT_W-1:0] pull_up_en_o, // connect pull-up
	output logic [PORT_W-1:0] pull_dn_en_o, // connect pull-down
	output logic [PORT_W-1:0] pin_irq_flag_o, // sticky request flags
	output logic irq_req_o, // any flag set
	output logic wake_o, // input combination wakes device
	output logic branch_condition_1_o, // debounced bit 0
	output logic branch_condition_2_o, // debounced bit 1
	output logic branch_condition_3_o, // debounced bit 2
	output logic [1:0] event_clk_o, // counter clocks from bits 0 and 3
	output logic millisecond_counter_ctrl_o // start/stop from bit 3
);
	// software registers
	logic [PORT_W-1:0] irq_en_reg;
	logic [PORT_W-1:0] flag_reg;
	logic [PORT_W-1:0] flag_next;
	logic [PORT_W-1:0] edge_sel_reg;
	logic [PORT_W-1:0] deb_byp_reg;
	logic [PORT_W-1:0] pull_inh_reg;
	logic [PORT_W-1:0] presc_reg;
	logic [PORT_W-1:0] freq_opt_reg;
	logic [PORT_W-1:0] combo_reg;
	logic [PORT_W-1:0] rdata_reg;
	logic [PORT_W-1:0] rdata_next;
	// input path
	logic [PORT_W-1:0] sync1_reg;
	logic [PORT_W-1:0] sync2_reg;
	logic [PORT_W-1:0] sync3_reg;
	logic [PORT_W-1:0] clean_reg;
	logic [PORT_W-1:0] deb_w;
	logic [PORT_W-1:0] src_w;
	logic [PORT_W-1:0] trig_w;
	logic [PORT_W-1:0] trig_prev_reg;
	logic [PORT_W-1:0] set_w;
	logic [PORT_W-1:0] clr_w;
	// divider
	logic [DIV_W-1:0] div_cnt_reg;
	logic [DIV_W-1:0] div_limit_w;
	logic div_end_w;
	logic tick_reg;
	// decodes
	logic wr_en_w;
	logic wr_flag_w;
	logic wr_edge_w;
	logic wr_byp_w;
	logic wr_inh_w;
	logic wr_presc_w;
	logic wr_opt_w;
	logic wr_combo_w;
	logic wake_opt_w;
	logic active_w;
	logic [PORT_W-1:0] pull_ok_w;

	// write decodes
	assign wr_en_w = reg_wr_i && (reg_addr_i == OFS_IRQ_EN);
	assign wr_flag_w = reg_wr_i && (reg_addr_i == OFS_IRQ_FLAG);
	assign wr_edge_w = reg_wr_i && (reg_addr_i == OFS_EDGE_SEL);
	assign wr_byp_w = reg_wr_i && (reg_addr_i == OFS_DEB_BYP);
	assign wr_inh_w = reg_wr_i && (reg_addr_i == OFS_PULL_INH);
	assign wr_presc_w = reg_wr_i && (reg_addr_i == OFS_PRESC);
	assign wr_opt_w = reg_wr_i && (reg_addr_i == OFS_FREQ_OPT);
	assign wr_combo_w = reg_wr_i && (reg_addr_i == OFS_WAKE_COMBO);

	// control registers, all cleared by reset
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			irq_en_reg <= RST_IRQ_EN;
			edge_sel_reg <= RST_EDGE_SEL;
			deb_byp_reg <= RST_DEB_BYP;
			pull_inh_reg <= RST_PULL_INH;
			presc_reg <= RST_PRESC;
			freq_opt_reg <= RST_FREQ_OPT;
			combo_reg <= RST_WAKE_COMBO;
		end else begin
			if (wr_en_w) irq_en_reg <= reg_wdata_i;
			if (wr_edge_w) edge_sel_reg <= reg_wdata_i;
			if (wr_byp_w) deb_byp_reg <= reg_wdata_i;
			if (wr_inh_w) pull_inh_reg <= reg_wdata_i;
			if (wr_presc_w) presc_reg <= reg_wdata_i;
			if (wr_opt_w) freq_opt_reg <= reg_wdata_i;
			if (wr_combo_w) combo_reg <= reg_wdata_i;
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		rdata_next = '0;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				OFS_PIN_LEVEL: rdata_next = clean_reg;
				OFS_IRQ_EN: rdata_next = irq_en_reg;
				OFS_IRQ_FLAG: rdata_next = flag_reg;
				OFS_EDGE_SEL: rdata_next = edge_sel_reg;
				OFS_DEB_BYP: rdata_next = deb_byp_reg;
				OFS_PULL_INH: rdata_next = pull_inh_reg;
				OFS_PRESC: rdata_next = presc_reg;
				OFS_FREQ_OPT: rdata_next = freq_opt_reg;
				OFS_WAKE_COMBO: rdata_next = combo_reg;
				default: rdata_next = '0;
			endcase
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) rdata_reg <= '0;
		else rdata_reg <= rdata_next;
	end
	assign reg_rdata_o = rdata_reg;

	// in sleep the inputs freeze unless wake-on-combination is armed
	assign wake_opt_w = freq_opt_reg[WAKE_BIT];
	assign active_w = !sleep_i || wake_opt_w;

	// three-stage synchroniser; a change counts when stages 2 and 3 agree
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
			clean_reg <= '0;
		end else begin
			sync1_reg <= input_pins_i;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			for (int b = 0; b < PORT_W; b++) begin
				if (active_w && (sync2_reg[b] == sync3_reg[b])) begin
					clean_reg[b] <= sync3_reg[b];
				end
			end
		end
	end

	// debounce tick divider; the tap follows the select bit at once
	assign div_limit_w = presc_reg[DEB_SEL_BIT] ?
		DIV_W'(DIV_FAST_P - 1) : DIV_W'(DIV_SLOW_P - 1);
	// compare with >= so a shorter tap never strands the counter
	assign div_end_w = (div_cnt_reg >= div_limit_w);

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			div_cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			div_cnt_reg <= div_end_w ? '0 : div_cnt_reg + 1'b1;
			tick_reg <= div_end_w;
		end
	end

	// one debouncer per bit, shared by interrupts, the event counter and branches
	generate
		for (genvar g = 0; g < PORT_W; g++) begin : g_deb
			ipirq_debounce u_deb (
				.ref_clk_i(ref_clk_i),
				.sys_rst_i(sys_rst_i),
				.tick_i(tick_reg),
				.level_i(clean_reg[g]),
				.level_o(deb_w[g])
			);
		end
	endgenerate

	// source select and polarity; a falling edge is a rising inverted level
	assign src_w = (deb_byp_reg & clean_reg) | (~deb_byp_reg & deb_w);
	assign trig_w = src_w ^ edge_sel_reg;
	// trig_prev tracks even when masked, so old edges are never recalled;
	// a polarity flip changes trig_w and may request, so mask first
	assign set_w = irq_en_reg & trig_w & ~trig_prev_reg;
	assign clr_w = wr_flag_w ? reg_wdata_i : '0;
	// set beats a clear in the same cycle
	assign flag_next = (flag_reg & ~clr_w) | set_w;

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			trig_prev_reg <= '0;
			flag_reg <= RST_IRQ_FLAG;
		end else begin
			trig_prev_reg <= trig_w;
			flag_reg <= flag_next;
		end
	end
	assign pin_irq_flag_o = flag_reg;
	assign irq_req_o = |flag_reg;

	// pulls: fitted option, not inhibited, awake or wake armed; both fitted is refused
	assign pull_ok_w = ~pull_inh_reg & ~(fab_pull_up_option_i & fab_pull_down_option_i)
		& {PORT_W{active_w}};
	assign pull_up_en_o = fab_pull_up_option_i & pull_ok_w;
	assign pull_dn_en_o = fab_pull_down_option_i & pull_ok_w;

	// wake on the programmed combination while asleep
	assign wake_o = sleep_i && wake_opt_w && (clean_reg == combo_reg);

	// taps to other blocks
	assign branch_condition_1_o = deb_w[0];
	assign branch_condition_2_o = deb_w[1];
	assign branch_condition_3_o = deb_w[2];
	assign event_clk_o = {trig_w[3], trig_w[0]};
	assign millisecond_counter_ctrl_o = clean_reg[3];

	// checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence pin_read_s;
		reg_rd_i && (reg_addr_i == OFS_PIN_LEVEL);
	endsequence
	sequence edge_direct_s(int b);
		deb_byp_reg[b] && irq_en_reg[b] && trig_w[b] && !trig_prev_reg[b];
	endsequence

	pin_read_a: assert property (pin_read_s |=> reg_rdata_o == $past(clean_reg))
		else $error("pin level read mismatch");
	en_reset_a: assert property ($fell(sys_rst_i) |-> irq_en_reg == 4'h0)
		else $error("enables not cleared by reset");
	masked_a: assert property (((flag_reg & ~$past(flag_reg) & ~$past(irq_en_reg)) == 4'h0))
		else $error("flag set while masked");
	clear_one_a: assert property (wr_flag_w && set_w == 4'h0
		|=> (flag_reg & $past(reg_wdata_i)) == 4'h0)
		else $error("write one did not clear flag");
	set_wins_a: assert property ((set_w & clr_w) != 4'h0
		|=> (flag_reg & $past(set_w)) == $past(set_w))
		else $error("clear beat a new request");
	direct_edge_a: assert property (edge_direct_s(0) |=> flag_reg[0])
		else $error("direct edge not flagged");
	pull_excl_a: assert property ((pull_up_en_o & pull_dn_en_o) == 4'h0 &&
		(pull_up_en_o & pull_inh_reg) == 4'h0)
		else $error("pull enable illegal");
	sleep_pull_a: assert property (sleep_i && !wake_opt_w
		|-> (pull_up_en_o | pull_dn_en_o) == 4'h0 ##1 $stable(clean_reg))
		else $error("input active in sleep");
	deb_tick_a: assert property ($changed(deb_w) |-> $past(tick_reg))
		else $error("debounced level moved without tick");

	// steps shared by the flag and tick checks
	sequence flag_write_s;
		wr_flag_w;
	endsequence
	sequence tick_s;
		tick_reg;
	endsequence

	// flags only move on a request or a software clear
	flag_hold_a: assert property (!wr_flag_w && set_w == 4'h0 |=> $stable(flag_reg))
		else $error("flag moved without cause");

	// writing zeros must leave every flag as it was
	zero_write_a: assert property (flag_write_s ##0 reg_wdata_i == 4'h0
		|=> flag_reg == ($past(flag_reg) | $past(set_w)))
		else $error("zero write changed a flag");

	// the request line is the plain or of the flags
	irq_or_a: assert property (irq_req_o == (flag_reg != 4'h0))
		else $error("request line disagrees with flags");

	// a new request needs some enable bit in the cycle before
	irq_en_need_a: assert property ($rose(irq_req_o) |-> $past(irq_en_reg) != 4'h0)
		else $error("request rose with all bits masked");

	// every enable bit is writable on its own
	en_write_a: assert property (wr_en_w |=> irq_en_reg == $past(reg_wdata_i))
		else $error("enable write lost");

	// read data stand only after a strobe, else zero
	read_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 4'h0)
		else $error("read data without strobe");

	// flag read shows which pin requested
	flag_read_a: assert property (reg_rd_i && reg_addr_i == OFS_IRQ_FLAG
		|=> reg_rdata_o == $past(flag_reg))
		else $error("flag read mismatch");

	// a new flag bit needs an active edge on that bit
	edge_set_a: assert property ((flag_reg & ~$past(flag_reg)
		& ~$past(trig_w & ~trig_prev_reg)) == 4'h0)
		else $error("flag set without edge");

	// pull-ups stay connected while the wake combination is armed
	pull_wake_a: assert property (sleep_i && wake_opt_w |-> pull_up_en_o ==
		(fab_pull_up_option_i & ~pull_inh_reg & ~fab_pull_down_option_i))
		else $error("pull dropped while wake armed");

	// a pull-down is never enabled where none is fitted
	pull_fit_a: assert property ((pull_dn_en_o & ~fab_pull_down_option_i) == 4'h0)
		else $error("pull-down without fitted resistor");

	// wake only while asleep with the option set
	wake_cond_a: assert property (wake_o |-> sleep_i && freq_opt_reg[WAKE_BIT])
		else $error("wake outside armed sleep");

	// branch condition 1 moves only on a debounce tick
	branch_tick_a: assert property ($changed(branch_condition_1_o) |-> $past(tick_reg))
		else $error("branch condition not debounced");

	// the counter start/stop follows agreeing sync stages, not the debouncer
	msc_sync_a: assert property ($changed(millisecond_counter_ctrl_o)
		|-> $past(sync2_reg[3]) == $past(sync3_reg[3]))
		else $error("start/stop moved before stages agreed");

	// the tick is a single-cycle enable pulse
	tick_pulse_a: assert property (tick_s |=> !tick_reg)
		else $error("debounce tick longer than a cycle");

	// the divider never runs past the selected tap once settled
	div_bound_a: assert property (!$changed(presc_reg) |-> div_cnt_reg <= div_limit_w)
		else $error("divider past its limit");
endmodule : ipirq_port

// ===== logic/ipirq_pkg.sv
// constants for the four-bit input port with per-bit interrupt flags
package ipirq_pkg;
	localparam int PORT_W = 4;
	localparam int ADDR_W = 4;
	// register offsets on the plain register port
	localparam logic [3:0] OFS_PIN_LEVEL = 4'h0;
	localparam logic [3:0] OFS_IRQ_EN = 4'h1;
	localparam logic [3:0] OFS_IRQ_FLAG = 4'h2;
	localparam logic [3:0] OFS_EDGE_SEL = 4'h3;
	localparam logic [3:0] OFS_DEB_BYP = 4'h4;
	localparam logic [3:0] OFS_PULL_INH = 4'h5;
	localparam logic [3:0] OFS_PRESC = 4'h6;
	localparam logic [3:0] OFS_FREQ_OPT = 4'h7;
	localparam logic [3:0] OFS_WAKE_COMBO = 4'h8;
	// field positions
	localparam int DEB_SEL_BIT = 0;
	localparam int WAKE_BIT = 3;
	// reset values
	localparam logic [3:0] RST_IRQ_EN = 4'h0;
	localparam logic [3:0] RST_IRQ_FLAG = 4'h0;
	localparam logic [3:0] RST_EDGE_SEL = 4'h0;
	localparam logic [3:0] RST_DEB_BYP = 4'h0;
	localparam logic [3:0] RST_PULL_INH = 4'h0;
	localparam logic [3:0] RST_PRESC = 4'h0;
	localparam logic [3:0] RST_FREQ_OPT = 4'h0;
	localparam logic [3:0] RST_WAKE_COMBO = 4'h0;
	// debounce clock taps and their periods in reference clock cycles
	localparam int unsigned SYS_CLK_HZ = 100_000_000;
	localparam int unsigned TAP_SLOW_HZ = 128;
	localparam int unsigned TAP_FAST_HZ = 1024;
	localparam int unsigned DIV_SLOW = SYS_CLK_HZ / TAP_SLOW_HZ;
	localparam int unsigned DIV_FAST = SYS_CLK_HZ / TAP_FAST_HZ;
	localparam int DIV_W = 20;
endpackage : ipirq_pkg

// ===== logic/ipirq_debounce.sv
// one-bit debouncer clocked by a slow tick enable
`timescale 1ns/1ps
module ipirq_debounce
	import ipirq_pkg::*;
(
	input wire logic ref_clk_i, // reference clock
	input wire logic sys_rst_i, // synchronous reset, high
	input wire logic tick_i, // debounce clock enable pulse
	input wire logic level_i, // synchronised input level
	output logic level_o // debounced level
);
	logic sample_reg;
	logic level_reg;
	logic agree_w;

	// a level counts once two successive ticks saw the same value
	assign agree_w = (level_i == sample_reg);
	assign level_o = level_reg;

	// sample on each tick, pass the level only when it held
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			sample_reg <= 1'b0;
			level_reg <= 1'b0;
		end else if (tick_i) begin
			sample_reg <= level_i;
			if (agree_w) begin
				level_reg <= level_i;
			end
		end
	end
endmodule : ipirq_debounce

// ===== tb/ipirq_switch.sv
// switch model that drives the input pins, with optional contact bounce
`timescale 1ns/1ps
module ipirq_switch (
	input wire logic clk_i, // reference clock
	input wire logic [3:0] lvl_i, // level the contacts settle to
	input wire logic bounce_i, // chatter on every change
	output logic [3:0] pins_o // pin levels
);
	logic [3:0] last = 4'h0;
	logic [3:0] old = 4'h0;
	int n = 9;
	// after a change the contacts chatter between old and new level
	always @(posedge clk_i) begin
		if (lvl_i != last) begin
			old <= last;
			last <= lvl_i;
			n <= 0;
		end else if (n < 9) begin
			n <= n + 1;
		end
		pins_o <= (bounce_i && n < 5 && !n[0]) ? old : lvl_i;
	end
	initial pins_o = 4'h0;
endmodule : ipirq_switch

// ===== tb/tb_ipirq_port.sv
// self-checking bench for the four-bit input port
`timescale 1ns/1ps
module tb_ipirq_port;
	import ipirq_pkg::*;
	logic clk, rst, wr, rd, bounce, sleep, rd_seen;
	logic [3:0] addr, wd, rdata, lvl, pins, fup, fdn, pu, pd, flag, v;
	logic irq, wake, bc1, bc2, bc3, millisecond_counter;
	logic [1:0] ev;
	logic [3:0] exp_q[$];
	int bad_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int seed = 88813;
	// small taps keep the debounce waits short
	ipirq_port #(.DIV_SLOW_P(8), .DIV_FAST_P(4)) i_dut (.ref_clk_i(clk), .sys_rst_i(rst),
		.reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .input_pins_i(pins), .fab_pull_up_option_i(fup),
		.fab_pull_down_option_i(fdn), .sleep_i(sleep), .pull_up_en_o(pu),
		.pull_dn_en_o(pd), .pin_irq_flag_o(flag), .irq_req_o(irq), .wake_o(wake),
		.branch_condition_1_o(bc1), .branch_condition_2_o(bc2),
		.branch_condition_3_o(bc3), .event_clk_o(ev), .millisecond_counter_ctrl_o(millisecond_counter));
	ipirq_switch i_sw (.clk_i(clk), .lvl_i(lvl), .bounce_i(bounce), .pins_o(pins));
	// 100 MHz clock
	always #5 clk = ~clk;
	task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic wr_reg(input logic [3:0] a, input logic [3:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	// the expected value is queued for the read monitor
	task automatic rd_reg(input logic [3:0] a, input logic [3:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask : rd_reg
	// read data stand only in the cycle after the strobe; also the hang limit
	always @(posedge clk) begin
		if (rd_seen)
			check("rdata", rdata, exp_q.pop_front());
		rd_seen <= rd;
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			stop_test();
		end
	end
	// main sequence
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{wr, rd, bounce, sleep, rd_seen} = 5'h0;
		{addr, wd, lvl} = 12'h0;
		fup = 4'h5;
		fdn = 4'h6;
		tick(8);
		rst <= 1'b0;
		for (int a = 1; a < 10; a++)
			rd_reg(a[3:0], 4'h0);
		wr_reg(OFS_PIN_LEVEL, 4'hf);
		rd_reg(OFS_PIN_LEVEL, 4'h0);
		repeat (4) begin
			v = 4'($random(seed));
			lvl <= v;
			tick(6);
			rd_reg(OFS_PIN_LEVEL, v);
			check("msc", {3'h0, millisecond_counter}, {3'h0, v[3]});
		end
		$display("test reset and pin read done");
		lvl <= 4'h0;
		wr_reg(OFS_DEB_BYP, 4'hb);
		wr_reg(OFS_IRQ_EN, 4'hf);
		rd_reg(OFS_IRQ_EN, 4'hf);
		tick(8);
		lvl <= 4'hb;
		tick(8);
		check("flag", flag, 4'hb);
		check("irq", {3'h0, irq}, 4'h1);
		rd_reg(OFS_IRQ_FLAG, 4'hb);
		wr_reg(OFS_IRQ_FLAG, 4'h4);
		rd_reg(OFS_IRQ_FLAG, 4'hb);
		wr_reg(OFS_IRQ_FLAG, 4'hf);
		tick(2);
		check("flag", flag, 4'h0);
		lvl <= 4'h0;
		tick(8);
		check("flag", flag, 4'h0);
		$display("test direct edges done");
		wr_reg(OFS_IRQ_EN, 4'h0);
		lvl <= 4'h1;
		tick(8);
		wr_reg(OFS_IRQ_EN, 4'h3);
		tick(4);
		rd_reg(OFS_IRQ_FLAG, 4'h0);
		lvl <= 4'h0;
		tick(8);
		lvl <= 4'h1;
		tick(8);
		check("flag", flag, 4'h1);
		wr_reg(OFS_IRQ_FLAG, 4'h1);
		wr_reg(OFS_IRQ_EN, 4'h2);
		wr_reg(OFS_EDGE_SEL, 4'h2);
		tick(3);
		check("flag", flag, 4'h2);
		wr_reg(OFS_IRQ_FLAG, 4'h2);
		lvl <= 4'h3;
		tick(8);
		check("flag", flag, 4'h0);
		lvl <= 4'h1;
		tick(8);
		check("flag", flag, 4'h2);
		$display("test mask and edge select done");
		wr_reg(OFS_EDGE_SEL, 4'h8);
		tick(2);
		check("event", {2'h0, ev}, 4'h3);
		lvl <= 4'h8;
		tick(8);
		check("event", {2'h0, ev}, 4'h0);
		check("msc", {3'h0, millisecond_counter}, 4'h1);
		wr_reg(OFS_EDGE_SEL, 4'h0);
		wr_reg(OFS_IRQ_FLAG, 4'hf);
		wr_reg(OFS_IRQ_EN, 4'h4);
		bounce <= 1'b1;
		lvl <= 4'h4;
		tick(6);
		check("flag", flag, 4'h0);
		check("bc3", {3'h0, bc3}, 4'h0);
		tick(40);
		check("flag", flag, 4'h4);
		check("bc3", {3'h0, bc3}, 4'h1);
		check("bc1", {3'h0, bc1}, 4'h0);
		wr_reg(OFS_PRESC, 4'h1);
		lvl <= 4'h6;
		// chatter, three sync stages and two fast ticks need up to about 20 cycles
		tick(24);
		check("bc2", {3'h0, bc2}, 4'h1);
		$display("test debounce done");
		check("pull up", pu, 4'h1);
		check("pull down", pd, 4'h2);
		wr_reg(OFS_PULL_INH, 4'h1);
		tick(1);
		check("pull up", pu, 4'h0);
		sleep <= 1'b1;
		tick(2);
		check("pull down", pd, 4'h0);
		wr_reg(OFS_FREQ_OPT, 4'h8);
		wr_reg(OFS_WAKE_COMBO, 4'h6);
		tick(2);
		check("pull down", pd, 4'h2);
		check("wake", {3'h0, wake}, 4'h1);
		$display("test pulls and sleep done");
		tick(3);
		stop_test();
	end
endmodule : tb_ipirq_port
